// [src/accel_spi_pkg.sv]
// Shared constants for the accelerometer sensor-read SPI link
`default_nettype none
package accel_spi_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  // Request fields
  localparam int REQ_TAG_HI = 15;
  localparam int REQ_TAG_MID = 14;
  localparam int REQ_SAMPLE_SEL = 13;
  localparam int REQ_TAG_LO = 12;
  localparam int REQ_CHAN_LSB = 0;
  // Response kinds and fault classes
  localparam logic [1:0] KIND_UNUSED = 2'h0;
  localparam logic [1:0] KIND_SAMPLE = 2'h1;
  localparam logic [1:0] KIND_SELF_TEST = 2'h2;
  localparam logic [1:0] KIND_EXCEPTION = 2'h3;
  localparam logic [1:0] FAULT_SENSOR = 2'h0;
  // Channel codes, low two bits of channel_code
  localparam logic [1:0] CHAN_X_LOW = 2'h0;
  localparam logic [1:0] CHAN_Y_LOW = 2'h1;
  localparam logic [1:0] CHAN_X_HIGH = 2'h2;
  localparam logic [1:0] CHAN_Y_HIGH = 2'h3;
  localparam logic [3:0] MASK_X = 4'h5;
  localparam logic [3:0] MASK_Y = 4'ha;
  localparam logic [3:0] MASK_HIGH = 4'hc;
  // Freeze policies
  localparam logic [1:0] FREEZE_BOTH = 2'h0;
  localparam logic [1:0] FREEZE_CHAN = 2'h1;
  localparam logic [1:0] FREEZE_HIGH = 2'h2;
  localparam logic [1:0] FREEZE_NONE = 2'h3;
  // Sample layout
  localparam int SAMPLE_W = 14;
  localparam int LOW_PART_W = 4;
  localparam int PAYLOAD_W = 10;
  // Value shifted out before any request: tag 0, kind unused, odd parity
  localparam logic [15:0] RESP_RESET = 16'h1000;
  // Host timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS = 35;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int FRAME_GAP_NS = 100;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
endpackage
`default_nettype wire

// [src/spi_link_if.sv]
// Four-wire SPI link between host and accelerometer
`default_nettype none
interface spi_link_if;
  logic sck;
  logic slaveSelectN;
  logic mosi;
  logic miso;
  logic misoOe;
  modport device (input sck, input slaveSelectN, input mosi, output miso, output misoOe);
  modport host (output sck, output slaveSelectN, output mosi, input miso, input misoOe);
endinterface
`default_nettype wire

// [src/accel_spi_device.sv]
// Accelerometer end: SPI slave frame engine and sensor response builder
//
// Summary of operation
// [R1] 16-bit full-duplex word, MSB first
// [R2] Select low enables clock and MISO drive
// [R3] Change on falling, sample on rising
// [R4] Slave only, never drives clock
// [R5] Word latched on falling edge after 16th
// [R6] Request applied before next frame starts
// [R7] Bit 13 selects sensor read
// [R8] Channel code picks output byte
// [R9] Request bits 11:4 ignored
// [R10] Sequence tag echoed in bits 15:13
// [R11] Bit 12 makes word parity odd
// [R12] Bits 11:10 give payload kind
// [R13] Self-test kind when self-check or comp-disable
// [R14] Exception fault class in bits 9:8
// [R15] Exception bits 7:5 and 4,1,0 zero
// [R16] Bit 3 flags read while powered down
// [R17] Bit 2 flags heater regulation loss
// [R18] Payload right-justified, zero filled
// [R19] High byte upper ten, low byte four
// [R20] Freeze policy holds samples until read
// [R21] Deselected: ignore clock and data
// [R22] Response returned in following frame
// [R23] Control frames passed out, no response
`default_nettype none
module accel_spi_device (
  spi_link_if.device link,
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [13:0] xSample,
  input wire logic [13:0] ySample,
  input wire logic selfCheckEnable,
  input wire logic compDisable,
  input wire logic poweredDown,
  input wire logic regulationLoss,
  input wire logic [1:0] freezePolicy,
  output logic [15:0] ctrlReqWord,
  output logic ctrlReqValid
);
  localparam logic [4:0] FRAME_CNT = 5'(accel_spi_pkg::FRAME_BITS);

  function automatic logic [3:0] nextMask(input logic [1:0] pol, input logic [3:0] m,
                                          input logic [3:0] sel);
    logic [3:0] n;
    n = m | sel;
    case (pol)
      accel_spi_pkg::FREEZE_BOTH: begin
        nextMask = (&n) ? 4'h0 : n;
      end
      accel_spi_pkg::FREEZE_CHAN: begin
        nextMask = n;
        if ((n & accel_spi_pkg::MASK_X) == accel_spi_pkg::MASK_X) begin
          nextMask = nextMask & ~accel_spi_pkg::MASK_X;
        end
        if ((n & accel_spi_pkg::MASK_Y) == accel_spi_pkg::MASK_Y) begin
          nextMask = nextMask & ~accel_spi_pkg::MASK_Y;
        end
      end
      accel_spi_pkg::FREEZE_HIGH: begin
        // Low-byte bits left by another policy are dropped, or this never clears
        n = (m | sel) & accel_spi_pkg::MASK_HIGH;
        nextMask = (n == accel_spi_pkg::MASK_HIGH) ? 4'h0 : n;
      end
      default: begin
        nextMask = 4'h0;
      end
    endcase
  endfunction

  logic [4:0] bitCnt_r;
  logic [15:0] rxShift_r;
  logic [15:0] txShift_r;
  logic started_r;
  logic captured_r;
  logic [15:0] reqWord_r;
  logic reqToggle_r;
  logic [15:0] respWord_r;
  logic [2:0] togSync_r;
  logic [3:0] readMask_r;
  logic [13:0] xHeld_r;
  logic [13:0] yHeld_r;
  logic [15:0] ctrlReqWord_r;
  logic ctrlReqValid_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the master's clock; shift state cleared while deselected, request word kept

  // Shift in on rising edges; clocks past the sixteenth are ignored
  always_ff @(posedge link.sck or posedge link.slaveSelectN) begin
    if (link.slaveSelectN) begin // see [R21] see [R2]
      bitCnt_r <= 5'h00;
      rxShift_r <= 16'h0000;
    end else if (bitCnt_r != FRAME_CNT) begin // see [R1] see [R3]
      bitCnt_r <= bitCnt_r + 5'h01;
      rxShift_r <= {rxShift_r[14:0], link.mosi};
    end
  end

  // Shift out on falling edges; first bit stands before the first edge
  always_ff @(negedge link.sck or posedge link.slaveSelectN) begin
    if (link.slaveSelectN) begin
      txShift_r <= 16'h0000;
      started_r <= 1'b0;
      captured_r <= 1'b0;
    end else begin
      if (!started_r) begin // see [R22]
        txShift_r <= {respWord_r[14:0], 1'b0};
        started_r <= 1'b1;
      end else begin
        txShift_r <= {txShift_r[14:0], 1'b0}; // see [R3]
      end
      if (bitCnt_r == FRAME_CNT) begin
        captured_r <= 1'b1;
      end
    end
  end

  // Request survives deselect so the other domain can read it later
  always_ff @(negedge link.sck or negedge arst_n) begin
    if (!arst_n) begin
      reqWord_r <= 16'h0000;
      reqToggle_r <= 1'b0;
    end else if (bitCnt_r == FRAME_CNT && !captured_r) begin // see [R5]
      reqWord_r <= rxShift_r;
      reqToggle_r <= ~reqToggle_r;
    end
  end

  // Device only listens to the clock and select, never drives them
  assign link.miso = started_r ? txShift_r[15] : respWord_r[15]; // see [R4] see [R1]
  assign link.misoOe = ~link.slaveSelectN; // see [R2]

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: request decode, freeze and response build

  wire reqEvent = togSync_r[2] ^ togSync_r[1];
  wire isSensor = reqWord_r[accel_spi_pkg::REQ_SAMPLE_SEL]; // see [R7]
  // Only bits 1:0 of the channel code matter; 11:4 are never looked at
  wire [1:0] chanSel = reqWord_r[accel_spi_pkg::REQ_CHAN_LSB +: 2]; // see [R8] see [R9]
  wire [3:0] selOneHot = 4'h1 << chanSel;
  // Tag top bit rides in request bit 12, the lower two in bits 15:14
  wire [2:0] seqTag = {reqWord_r[accel_spi_pkg::REQ_TAG_LO],
                       reqWord_r[accel_spi_pkg::REQ_TAG_HI],
                       reqWord_r[accel_spi_pkg::REQ_TAG_MID]};
  wire faultNow = poweredDown | regulationLoss; // see [R16] see [R17]
  wire selfTestNow = selfCheckEnable | compDisable;
  wire policyChan = freezePolicy == accel_spi_pkg::FREEZE_CHAN;
  // A mask left from an earlier policy must not stall continuous update
  wire policyNone = freezePolicy == accel_spi_pkg::FREEZE_NONE;
  wire xHold = policyChan ? |(readMask_r & accel_spi_pkg::MASK_X) : |readMask_r;
  wire yHold = policyChan ? |(readMask_r & accel_spi_pkg::MASK_Y) : |readMask_r;
  wire xFrozen = xHold & ~policyNone; // see [R20]
  wire yFrozen = yHold & ~policyNone;
  wire [13:0] chanSample = chanSel[0] ? yHeld_r : xHeld_r;
  wire [9:0] payload = chanSel[1] ? chanSample[13:4]
                                  : {6'h00, chanSample[3:0]}; // see [R19] see [R18]
  wire [1:0] dataKind = selfTestNow ? accel_spi_pkg::KIND_SELF_TEST
                                    : accel_spi_pkg::KIND_SAMPLE; // see [R13]
  wire [11:0] excBody = {accel_spi_pkg::KIND_EXCEPTION, accel_spi_pkg::FAULT_SENSOR, // see [R14]
                         3'h0, 1'b0, // see [R15]
                         poweredDown, regulationLoss, 2'h0}; // see [R16] see [R17]
  wire [11:0] respBody = faultNow ? excBody : {dataKind, payload}; // see [R12]
  wire respParity = ~^{seqTag, respBody}; // see [R11]
  wire [15:0] respNext = {seqTag, respParity, respBody}; // see [R10]

  // Toggle crossing; the first stage feeds only the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      togSync_r <= 3'h0;
    end else begin
      togSync_r <= {togSync_r[1:0], reqToggle_r};
    end
  end

  // Sensor frames load the next response; others go to the control handler
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      respWord_r <= accel_spi_pkg::RESP_RESET;
      ctrlReqWord_r <= 16'h0000;
      ctrlReqValid_r <= 1'b0;
    end else begin
      ctrlReqValid_r <= reqEvent & ~isSensor; // see [R23]
      if (reqEvent && isSensor) begin // see [R6]
        respWord_r <= respNext;
      end
      if (reqEvent && !isSensor) begin
        ctrlReqWord_r <= reqWord_r;
      end
    end
  end

  // Reads that return an exception do not count toward unfreezing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readMask_r <= 4'h0;
      xHeld_r <= 14'h0000;
      yHeld_r <= 14'h0000;
    end else begin
      if (reqEvent && isSensor && !faultNow) begin // see [R20]
        readMask_r <= nextMask(freezePolicy, readMask_r, selOneHot);
      end
      if (!xFrozen) begin
        xHeld_r <= xSample;
      end
      if (!yFrozen) begin
        yHeld_r <= ySample;
      end
    end
  end

  assign ctrlReqWord = ctrlReqWord_r;
  assign ctrlReqValid = ctrlReqValid_r;
endmodule
`default_nettype wire

// [src/accel_spi_host.sv]
// Host end: SPI master that runs one 16-bit frame per request
`default_nettype none
module accel_spi_host #(
  parameter int HALF_CYC = accel_spi_pkg::SCK_HALF_CYC,
  parameter int GAP_CYC = accel_spi_pkg::FRAME_GAP_CYC
) (
  spi_link_if.host link,
  input wire logic clock,
  input wire logic arst_n,
  input wire logic startReq,
  input wire logic [15:0] reqWord,
  output logic busy,
  output logic [15:0] respWord,
  output logic respValid
);
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} host_state_e;

  localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
  localparam logic [7:0] GAP_END = 8'(GAP_CYC - 1);
  localparam logic [4:0] LAST_BIT = 5'(accel_spi_pkg::FRAME_BITS - 1);

  host_state_e state_r;
  logic [7:0] divCnt_r;
  logic [4:0] bitCnt_r;
  logic [15:0] txShift_r;
  logic [15:0] rxShift_r;
  logic [1:0] misoSync_r;
  logic sck_r;
  logic ssN_r;
  logic mosi_r;
  logic busy_r;
  logic [15:0] respWord_r;
  logic respValid_r;

  wire halfDone = divCnt_r == HALF_END;
  wire gapDone = divCnt_r == GAP_END;
  wire misoIn = misoSync_r[1];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      misoSync_r <= 2'h0;
    end else begin
      misoSync_r <= {misoSync_r[0], link.miso};
    end
  end

  // Clock idles low; data moves on falling edges, sampled before rising
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      divCnt_r <= 8'h00;
      bitCnt_r <= 5'h00;
      txShift_r <= 16'h0000;
      rxShift_r <= 16'h0000;
      sck_r <= 1'b0;
      ssN_r <= 1'b1;
      mosi_r <= 1'b0;
      busy_r <= 1'b0;
      respWord_r <= 16'h0000;
      respValid_r <= 1'b0;
    end else begin
      respValid_r <= 1'b0;
      divCnt_r <= divCnt_r + 8'h01;
      case (state_r)
        ST_IDLE: begin
          divCnt_r <= 8'h00;
          if (startReq) begin
            ssN_r <= 1'b0;
            busy_r <= 1'b1;
            txShift_r <= reqWord;
            mosi_r <= reqWord[15];
            bitCnt_r <= 5'h00;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (halfDone) begin
            divCnt_r <= 8'h00;
            sck_r <= 1'b1;
            rxShift_r <= {rxShift_r[14:0], misoIn};
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (halfDone) begin
            divCnt_r <= 8'h00;
            sck_r <= 1'b0;
            if (bitCnt_r == LAST_BIT) begin
              state_r <= ST_TAIL;
            end else begin
              bitCnt_r <= bitCnt_r + 5'h01;
              txShift_r <= {txShift_r[14:0], 1'b0};
              mosi_r <= txShift_r[14];
              state_r <= ST_LOW;
            end
          end
        end
        ST_TAIL: begin
          if (halfDone) begin
            divCnt_r <= 8'h00;
            ssN_r <= 1'b1;
            respWord_r <= rxShift_r;
            respValid_r <= 1'b1;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Gap lets the device load its next response before reselect
          if (gapDone) begin
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.sck = sck_r;
  assign link.slaveSelectN = ssN_r;
  assign link.mosi = mosi_r;
  assign busy = busy_r;
  assign respWord = respWord_r;
  assign respValid = respValid_r;
endmodule
`default_nettype wire

// [tb/accel_spi_sensor_read_slave_properties.sv]
// Link-side checker for the sensor-read SPI frame engine
`default_nettype none
module accel_spi_sensor_read_slave_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic slaveSelectN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic sck_r, ss_r, seen_r;
  logic [4:0] rises_r;
  logic [15:0] misoW_r, mosiW_r;
  logic [2:0] tag_r;
  wire logic rise = sck && !sck_r && !slaveSelectN;
  wire logic frameEnd = slaveSelectN && !ss_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {sck_r, ss_r, rises_r, misoW_r, mosiW_r} <= {2'h1, 37'h0};
    end else begin
      sck_r <= sck;
      ss_r <= slaveSelectN;
      rises_r <= slaveSelectN ? 5'h00 : rises_r + 5'(rise);
      if (rise) begin
        misoW_r <= {misoW_r[14:0], miso};
        mosiW_r <= {mosiW_r[14:0], mosi};
      end
    end
  end
  // Tag of the last sensor request; its response shows in the next frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {seen_r, tag_r} <= 4'h0;
    end else if (frameEnd && mosiW_r[13]) begin
      {seen_r, tag_r} <= {1'h1, mosiW_r[12], mosiW_r[15:14]};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_oe_follows_select: assert property (misoOe == !slaveSelectN)
    else $error("miso enable does not follow select");
  chk_clock_idle_low: assert property (slaveSelectN |-> !sck)
    else $error("link clock active while deselected");
  chk_mosi_rise_stable: assert property (sck && !slaveSelectN |-> $stable(mosi))
    else $error("mosi moved while clock high");
  chk_miso_rise_stable: assert property (
    sck && $past(sck) && !slaveSelectN |-> $stable(miso))
    else $error("miso moved while clock high");
  chk_sixteen_rises: assert property ($rose(slaveSelectN) |-> rises_r == 5'h10)
    else $error("frame did not have sixteen clock rises");
  chk_parity_odd: assert property ($rose(slaveSelectN) |-> ^misoW_r)
    else $error("response word parity is even");
  chk_tag_echo: assert property (
    $rose(slaveSelectN) && seen_r |-> misoW_r[15:13] == tag_r)
    else $error("response tag differs from request");
  chk_kind_used: assert property (
    $rose(slaveSelectN) && seen_r |-> misoW_r[11:10] != 2'h0)
    else $error("response kind unused after sensor request");
  chk_exception_zero: assert property (
    $rose(slaveSelectN) && misoW_r[11:10] == 2'h3
    |-> misoW_r[9:4] == 6'h00 && misoW_r[1:0] == 2'h0)
    else $error("exception word has stray bits");
  chk_frame_bounded: assert property ($fell(slaveSelectN) |-> ##[16:300] slaveSelectN)
    else $error("frame did not end in time");
  cover property ($rose(slaveSelectN) && misoW_r[11:10] == 2'h1);
  cover property ($rose(slaveSelectN) && misoW_r[11:10] == 2'h2);
  cover property ($rose(slaveSelectN) && misoW_r[11:10] == 2'h3);
endmodule
`default_nettype wire

// [tb/test_accel_spi_sensor_read_slave.sv]
// Self-checking bench joining host and device ends over the SPI link
`default_nettype none
module test_accel_spi_sensor_read_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, arst_n, startReq, busy, respValid, ctrlReqValid;
  logic selfCheckEnable, compDisable, poweredDown, regulationLoss;
  logic [15:0] reqWord, respWord, ctrlReqWord, ctrlSeen, pend;
  logic [13:0] xSample, ySample, x0;
  logic [1:0] freezePolicy;
  int miscompares, testsRun;
  spi_link_if link();
  accel_spi_host #(.HALF_CYC(4), .GAP_CYC(8)) accel_spi_host_inst (.link(link), .clock(clock),
    .arst_n(arst_n), .startReq(startReq), .reqWord(reqWord), .busy(busy),
    .respWord(respWord), .respValid(respValid));
  accel_spi_device accel_spi_device_inst (.link(link), .clock(clock), .arst_n(arst_n),
    .xSample(xSample), .ySample(ySample), .selfCheckEnable(selfCheckEnable),
    .compDisable(compDisable), .poweredDown(poweredDown), .regulationLoss(regulationLoss),
    .freezePolicy(freezePolicy), .ctrlReqWord(ctrlReqWord), .ctrlReqValid(ctrlReqValid));
  accel_spi_sensor_read_slave_properties accel_spi_sensor_read_slave_properties_inst (
    .clock(clock), .arst_n(arst_n), .sck(link.sck), .slaveSelectN(link.slaveSelectN),
    .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (ctrlReqValid === 1'h1) ctrlSeen <= ctrlReqWord;
  ////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] mk(input logic [2:0] t, input logic [1:0] k,
                                     input logic [9:0] p);
    logic [15:0] w;
    w = {t, 1'h0, k, p};
    w[12] = ~^w;
    return w;
  endfunction
  // Host waits are bounded; a stuck handshake ends the run
  task automatic xfer(input logic [15:0] w);
    int n;
    reqWord = w;
    startReq = 1'h1;
    @(posedge clock);
    #1 startReq = 1'h0;
    for (n = 0; n < 400 && respValid !== 1'h1; n++) @(posedge clock) #1;
    for (n = n; n < 400 && busy !== 1'h0; n++) @(posedge clock) #1;
    if (n >= 400) begin
      miscompares++;
      giveVerdict();
    end
  endtask
  // Checks the previous request's answer, then queues this one's
  task automatic rd(input logic [2:0] t, input logic [1:0] ch, input logic [1:0] k,
                    input logic [9:0] p);
    xfer({t[1], t[0], 1'h1, t[2], 8'ha5 ^ {5'h0, t}, 2'h0, ch});
    check(respWord, pend);
    pend = mk(t, k, p);
  endtask
  function automatic logic [9:0] pay(input logic [1:0] ch);
    logic [13:0] v;
    v = ch[0] ? ySample : xSample;
    return ch[1] ? v[13:4] : {6'h00, v[3:0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, startReq, selfCheckEnable, compDisable, poweredDown, regulationLoss} = 6'h00;
    {reqWord, miscompares, testsRun} = '0;
    xSample = 14'h1a5c;
    ySample = 14'h2f31;
    freezePolicy = accel_spi_pkg::FREEZE_NONE;
    pend = accel_spi_pkg::RESP_RESET;
    repeat (16) @(posedge clock);
    #1 arst_n = 1'h1;
    for (int i = 0; i < 4; i++) begin
      rd(3'(i + 1), 2'(i), 2'h1, pay(2'(i)));
    end
    selfCheckEnable = 1'h1;
    rd(3'h5, 2'h3, 2'h2, pay(2'h3));
    {selfCheckEnable, compDisable} = 2'h1;
    rd(3'h6, 2'h0, 2'h2, pay(2'h0));
    poweredDown = 1'h1;
    rd(3'h7, 2'h2, 2'h3, 10'h008);
    {compDisable, poweredDown, regulationLoss} = 3'h1;
    rd(3'h0, 2'h1, 2'h3, 10'h004);
    poweredDown = 1'h1;
    rd(3'h3, 2'h2, 2'h3, 10'h00c);
    {poweredDown, regulationLoss} = 2'h0;
    xfer(16'h5a5a);
    check(respWord, pend);
    rd(3'h2, 2'h0, 2'h1, pay(2'h0));
    check(ctrlSeen, 16'h5a5a);
    freezePolicy = accel_spi_pkg::FREEZE_BOTH;
    x0 = xSample;
    rd(3'h4, 2'h0, 2'h1, pay(2'h0));
    xSample = 14'h0123;
    rd(3'h1, 2'h2, 2'h1, x0[13:4]);
    rd(3'h6, 2'h1, 2'h1, pay(2'h1));
    rd(3'h5, 2'h3, 2'h1, pay(2'h3));
    rd(3'h2, 2'h2, 2'h1, 10'h012);
    rd(3'h7, 2'h0, 2'h1, 10'h003);
    // Complete the four-byte set so the next policy starts unfrozen
    rd(3'h0, 2'h1, 2'h1, pay(2'h1));
    rd(3'h1, 2'h3, 2'h1, pay(2'h3));
    freezePolicy = accel_spi_pkg::FREEZE_CHAN;
    x0 = xSample;
    rd(3'h2, 2'h0, 2'h1, pay(2'h0));
    xSample = 14'h3c3c;
    ySample = 14'h0a5f;
    rd(3'h3, 2'h1, 2'h1, pay(2'h1));
    rd(3'h4, 2'h2, 2'h1, x0[13:4]);
    rd(3'h5, 2'h3, 2'h1, pay(2'h3));
    freezePolicy = accel_spi_pkg::FREEZE_HIGH;
    x0 = xSample;
    rd(3'h6, 2'h2, 2'h1, pay(2'h2));
    xSample = 14'h1111;
    rd(3'h7, 2'h0, 2'h1, {6'h00, x0[3:0]});
    rd(3'h0, 2'h3, 2'h1, pay(2'h3));
    // One more frame collects the last queued answer
    xfer(16'h0000);
    check(respWord, pend);
    giveVerdict();
  end
endmodule
`default_nettype wire
